// file: src/frc_defs.svh
// Constants for the fault, retry and restart control block.
// Assumes a 125 MHz core clock and a shared timebase tick every 200 us.
`ifndef FRC_DEFS_SVH
`define FRC_DEFS_SVH

`define FRC_NCH 8
`define FRC_CLK_NS 8
`define FRC_STEP_US 200
`define FRC_MAX_MS 13100
`define FRC_MAX_STEPS ((`FRC_MAX_MS * 1000) / `FRC_STEP_US)
`define FRC_QUIET_MS 6000
`define FRC_QUIET_TICKS ((`FRC_QUIET_MS * 1000) / `FRC_STEP_US)
`define FRC_OFF_MIN_NS 10000
`define FRC_OFF_MIN_CYC ((`FRC_OFF_MIN_NS + `FRC_CLK_NS - 1) / `FRC_CLK_NS)

`define FRC_SEL_OV 3'h0
`define FRC_SEL_UV 3'h1
`define FRC_SEL_LIM 3'h2
`define FRC_SEL_RTY 3'h3
`define FRC_SEL_RST 3'h4
`define FRC_SEL_PEAK 3'h5

`define FRC_LIM_MSB 2
`define FRC_LIM_INF 3'h7
`define FRC_MASK_RST 8'h00
`define FRC_LIM_RST 3'h0
`define FRC_DLY_RST 16'h0000
`define FRC_PEAK_RST 16'hf800

`endif

// file: src/frc_pkg.sv
// Types for the fault, retry and restart control block.
// Assumes frc_defs.svh is on the include path.
`include "frc_defs.svh"

package frc_pkg;

	typedef enum logic [2:0] {
		FRC_IDLE = 3'b001,
		FRC_WAIT = 3'b010,
		FRC_DONE = 3'b100
	} frc_state_t;

	typedef struct packed {
		logic [7:0] ov_mask;
		logic [7:0] uv_mask;
		logic [2:0] lim;
		logic [15:0] rty_raw;
		logic [15:0] rst_raw;
		logic [15:0] rd_data;
		logic rd_valid;
		logic oe_n;
		frc_state_t [`FRC_NCH-1:0] st;
		logic [`FRC_NCH-1:0][2:0] rcnt;
		logic [`FRC_NCH-1:0][15:0] ivl;
		logic [`FRC_NCH-1:0][15:0] quiet;
		logic [`FRC_NCH-1:0] fo_q;
		logic [`FRC_NCH-1:0] ctl_q;
		logic [`FRC_NCH-1:0] op_q;
		logic [`FRC_NCH-1:0] on_q;
		logic [`FRC_NCH-1:0][10:0] offc;
		logic [`FRC_NCH-1:0][15:0] offt;
		logic [`FRC_NCH-1:0][15:0] hold;
		logic [`FRC_NCH-1:0] hold_f;
		logic [`FRC_NCH-1:0] go;
		logic [`FRC_NCH-1:0][15:0] peak;
	} frc_state_s_t;

	typedef struct packed {
		logic [15:0] steps;
	} frc_conv_t;

endpackage

// file: src/frc_delay_conv.sv
// Converts a delay in L11 milliseconds to 200 us timebase steps.
// Assumes the input is a stored register value; result lags it by one clock.
`timescale 1ns/1ps
`include "frc_defs.svh"

module frc_delay_conv (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [15:0] l11,
	output logic [15:0] steps
);
	import frc_pkg::*;

	frc_conv_t s;
	frc_conv_t next_s;

	////////////////////////////////////////////////////////////////////////////
	// Scale, round to nearest step, limit
	always_comb begin
		logic signed [31:0] m5;
		logic signed [31:0] v;
		logic signed [4:0] e;
		logic [4:0] sh;
		m5 = 32'(signed'(l11[10:0])) * 32'sd5;
		e = signed'(l11[15:11]);
		sh = 5'(-e);
		v = 32'sd0;
		next_s = s;
		if (m5 > 32'sd0) begin
			if (e >= 5'sd0) begin
				v = m5 <<< e;
			end else begin
				v = (m5 + (32'sd1 <<< (sh - 5'd1))) >>> sh;
			end
		end
		if (v > 32'(`FRC_MAX_STEPS)) begin
			next_s.steps = 16'(`FRC_MAX_STEPS);
		end else begin
			next_s.steps = v[15:0];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign steps = s.steps;

endmodule

// file: src/frc_top.sv
// Fault response, retry and restart control for eight supply channels.
// Assumes fault, channel state and timebase tick inputs are synchronous.
//
// How it works
// - OV mask bit n lets channel n overvoltage pull input enable low.
// - UV mask bit n lets channel n undervoltage pull input enable low.
// - One global retry limit governs retries of any retry-enabled channel.
// - Limit field: 0 none, 1-6 that many, 7 unlimited; bits 7:3 read 0.
// - Retries per channel never exceed the programmed limit.
// - Six seconds without fault-off clears a channel's retry count.
// - Control pin or operation off-then-on clears that channel's count.
// - Any write of the retry limit clears all eight counts.
// - Retry interval between attempts timed on timebase ticks only.
// - Retry and restart delays are 16-bit L11 milliseconds on ticks.
// - Delays rounded to 200 us steps and limited to 13.1 seconds.
// - Delay registers read back exactly what was written.
// - Control off for 10 us then on holds channel off for restart delay.
// - Off periods already longer than restart delay get no extra hold.
// - Restart delay of zero disables the restart hold entirely.
// - Each channel keeps its highest measured output voltage.
// - No peak tracking on odd channels measuring sense current.
// - Peak resets to f800 at reset, page clear-faults, off-to-on.
// - Peak value is a 16-bit L16 voltage word.
`timescale 1ns/1ps
`include "frc_defs.svh"

module frc_top #(
	parameter int unsigned QUIET_TICKS = `FRC_QUIET_TICKS
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [2:0] reg_sel,
	input wire logic [2:0] reg_page,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic clear_faults,
	input wire logic [2:0] clear_page,
	input wire logic [7:0] output_overvoltage_fault,
	input wire logic [7:0] output_undervoltage_fault,
	input wire logic [7:0] faulted_off,
	input wire logic [7:0] retry_en,
	input wire logic [7:0] ctl_pin_on,
	input wire logic [7:0] op_on,
	input wire logic [7:0] chan_on,
	input wire logic [7:0] isense_mode,
	input wire logic shared_timebase_tick,
	input wire logic meas_valid,
	input wire logic [2:0] meas_chan,
	input wire logic [15:0] meas_value,
	input wire logic vin_en_in,
	output logic vin_en_out,
	output logic vin_en_oe_n,
	output logic [7:0] retry_go,
	output logic [7:0] retry_exhausted,
	output logic [7:0] restart_hold
);
	import frc_pkg::*;

	localparam logic [10:0] OFF_MIN = 11'(`FRC_OFF_MIN_CYC);
	localparam logic [15:0] QUIET_LAST = 16'(QUIET_TICKS - 1);

	frc_state_s_t s;
	frc_state_s_t next_s;
	logic [15:0] rty_ticks;
	logic [15:0] rst_ticks;
	logic pin_seen;

	////////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic rise(input logic cur, input logic prev);
		return cur & ~prev;
	endfunction

	function automatic logic exhausted(input logic [2:0] cnt, input logic [2:0] lim);
		return (lim == 3'h0) || (lim != `FRC_LIM_INF && cnt >= lim);
	endfunction

	function automatic logic [15:0] rd_mux(input frc_state_s_t r, input logic [2:0] sel,
		input logic [2:0] page);
		case (sel)
		`FRC_SEL_OV: rd_mux = {8'h00, r.ov_mask};
		`FRC_SEL_UV: rd_mux = {8'h00, r.uv_mask};
		`FRC_SEL_LIM: rd_mux = {13'h0000, r.lim};
		`FRC_SEL_RTY: rd_mux = r.rty_raw;
		`FRC_SEL_RST: rd_mux = r.rst_raw;
		`FRC_SEL_PEAK: rd_mux = r.peak[page];
		default: rd_mux = 16'h0000;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Delay conversion
	frc_delay_conv u_rty_conv (
		.clk(clk),
		.rstn(rstn),
		.l11(s.rty_raw),
		.steps(rty_ticks)
	);

	frc_delay_conv u_rst_conv (
		.clk(clk),
		.rstn(rstn),
		.l11(s.rst_raw),
		.steps(rst_ticks)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic pull;
		logic clr_all;
		logic ev;
		logic odd_cur;
		pull = 1'b0;
		clr_all = 1'b0;
		ev = 1'b0;
		odd_cur = 1'b0;
		next_s = s;
		next_s.go = '0;
		next_s.rd_valid = reg_rd_en;

		// Input enable pull-down
		pull = |(output_overvoltage_fault & s.ov_mask);
		pull = pull | (|(output_undervoltage_fault & s.uv_mask));
		next_s.oe_n = ~pull;

		// Register writes
		if (reg_wr_en) begin
			case (reg_sel)
			`FRC_SEL_OV: next_s.ov_mask = reg_wdata[7:0];
			`FRC_SEL_UV: next_s.uv_mask = reg_wdata[7:0];
			`FRC_SEL_LIM: begin
				next_s.lim = reg_wdata[`FRC_LIM_MSB:0];
				clr_all = 1'b1;
			end
			`FRC_SEL_RTY: next_s.rty_raw = reg_wdata;
			`FRC_SEL_RST: next_s.rst_raw = reg_wdata;
			default: ;
			endcase
		end
		if (reg_rd_en) begin
			next_s.rd_data = rd_mux(s, reg_sel, reg_page);
		end

		for (int i = 0; i < `FRC_NCH; i++) begin
			next_s.fo_q[i] = faulted_off[i];
			next_s.ctl_q[i] = ctl_pin_on[i];
			next_s.op_q[i] = op_on[i];
			next_s.on_q[i] = chan_on[i];

			// Quiet timer
			if (faulted_off[i] || s.rcnt[i] == 3'h0) begin
				next_s.quiet[i] = 16'h0000;
			end else if (shared_timebase_tick) begin
				if (s.quiet[i] >= QUIET_LAST) begin
					next_s.quiet[i] = 16'h0000;
					next_s.rcnt[i] = 3'h0;
				end else begin
					next_s.quiet[i] = s.quiet[i] + 16'h0001;
				end
			end

			// Count clears
			if (clr_all || rise(ctl_pin_on[i], s.ctl_q[i]) || rise(op_on[i], s.op_q[i])) begin
				next_s.rcnt[i] = 3'h0;
				next_s.quiet[i] = 16'h0000;
				next_s.st[i] = FRC_IDLE;
			end

			// Retry sequence
			ev = faulted_off[i] & ~s.fo_q[i] & retry_en[i];
			case (s.st[i])
			FRC_IDLE: begin
				if (ev) begin
					if (exhausted(next_s.rcnt[i], s.lim)) begin
						next_s.st[i] = FRC_DONE;
					end else begin
						next_s.st[i] = FRC_WAIT;
						next_s.ivl[i] = rty_ticks;
					end
				end
			end
			FRC_WAIT: begin
				if (shared_timebase_tick) begin
					if (s.ivl[i] <= 16'h0001) begin
						next_s.ivl[i] = 16'h0000;
						next_s.go[i] = 1'b1;
						next_s.st[i] = FRC_IDLE;
						if (next_s.rcnt[i] != 3'h7) begin
							next_s.rcnt[i] = next_s.rcnt[i] + 3'h1;
						end
					end else begin
						next_s.ivl[i] = s.ivl[i] - 16'h0001;
					end
				end
			end
			FRC_DONE: ;
			default: next_s.st[i] = FRC_IDLE;
			endcase

			// Restart minimum off time
			if (ctl_pin_on[i]) begin
				next_s.offc[i] = 11'h000;
				next_s.offt[i] = 16'h0000;
			end else begin
				if (s.offc[i] < OFF_MIN) begin
					next_s.offc[i] = s.offc[i] + 11'h001;
				end
				if (shared_timebase_tick && s.offt[i] != 16'hffff) begin
					next_s.offt[i] = s.offt[i] + 16'h0001;
				end
			end
			if (rise(ctl_pin_on[i], s.ctl_q[i]) && rst_ticks != 16'h0000
				&& s.offc[i] >= OFF_MIN && s.offt[i] < rst_ticks) begin
				next_s.hold[i] = rst_ticks - s.offt[i];
			end else if (shared_timebase_tick && s.hold[i] != 16'h0000) begin
				next_s.hold[i] = s.hold[i] - 16'h0001;
			end
			next_s.hold_f[i] = next_s.hold[i] != 16'h0000;

			// Peak output voltage
			odd_cur = (i % 2 == 1) && isense_mode[i];
			if (rise(chan_on[i], s.on_q[i]) || (clear_faults && clear_page == 3'(i))) begin
				next_s.peak[i] = `FRC_PEAK_RST;
			end else if (meas_valid && meas_chan == 3'(i) && !odd_cur
				&& (s.peak[i] == `FRC_PEAK_RST || meas_value > s.peak[i])) begin
				next_s.peak[i] = meas_value;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
			s.ov_mask <= `FRC_MASK_RST;
			s.uv_mask <= `FRC_MASK_RST;
			s.lim <= `FRC_LIM_RST;
			s.rty_raw <= `FRC_DLY_RST;
			s.rst_raw <= `FRC_DLY_RST;
			s.oe_n <= 1'b1;
			s.st <= '{default: FRC_IDLE};
			s.ctl_q <= '1;
			s.op_q <= '1;
			s.peak <= {`FRC_NCH{`FRC_PEAK_RST}};
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign reg_rdata = s.rd_data;
	assign reg_rvalid = s.rd_valid;
	assign vin_en_out = 1'b0;
	assign vin_en_oe_n = s.oe_n;
	assign retry_go = s.go;
	assign restart_hold = s.hold_f;
	assign pin_seen = vin_en_in;

	always_comb begin
		for (int i = 0; i < `FRC_NCH; i++) begin
			retry_exhausted[i] = s.st[i][2];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence ov_hit_s;
		|(output_overvoltage_fault & s.ov_mask);
	endsequence

	sequence uv_hit_s;
		|(output_undervoltage_fault & s.uv_mask);
	endsequence

	sequence last_tick_s;
		s.st[3] == FRC_WAIT && shared_timebase_tick && s.ivl[3] <= 16'h0001;
	endsequence

	vin_ov_pull_a: assert property (ov_hit_s |=> !vin_en_oe_n)
		else $error("ov fault did not pull input enable");

	vin_uv_pull_a: assert property (uv_hit_s |=> !vin_en_oe_n)
		else $error("uv fault did not pull input enable");

	vin_release_a: assert property (
		!(|(output_overvoltage_fault & s.ov_mask))
		&& !(|(output_undervoltage_fault & s.uv_mask)) |=> vin_en_oe_n)
		else $error("input enable pulled without masked fault");

	lim_upper_zero_a: assert property (
		reg_rd_en && reg_sel == `FRC_SEL_LIM |=> reg_rvalid && reg_rdata[15:3] == 13'h0000)
		else $error("retry limit upper bits not zero");

	lim_write_clr_a: assert property (
		reg_wr_en && reg_sel == `FRC_SEL_LIM |=> s.rcnt[3] == 3'h0 && s.rcnt[0] == 3'h0)
		else $error("limit write did not clear counts");

	retry_bound_a: assert property (
		s.lim != `FRC_LIM_INF |-> s.rcnt[3] <= s.lim || s.rcnt[3] == 3'h0)
		else $error("retry count above limit");

	go_timing_a: assert property (last_tick_s |=> retry_go[3] ##1 !retry_go[3])
		else $error("retry attempt not issued at interval end");

	go_cause_a: assert property ($rose(retry_go[3]) |-> $past(s.st[3]) == FRC_WAIT)
		else $error("retry attempt without waiting state");

	peak_clear_a: assert property (
		clear_faults && clear_page == 3'h2 |=> s.peak[2] == `FRC_PEAK_RST)
		else $error("peak not reset by clear faults");

	restart_off_a: assert property (
		rst_ticks == 16'h0000 && !restart_hold[0] |=> !restart_hold[0])
		else $error("restart hold with zero delay");

	rty_readback_a: assert property (
		reg_wr_en && reg_sel == `FRC_SEL_RTY ##2 reg_rd_en && reg_sel == `FRC_SEL_RTY
		&& !reg_wr_en |=> reg_rdata == $past(reg_wdata, 3))
		else $error("retry delay readback differs");

	exh_stay_a: assert property (
		retry_exhausted[3] && !reg_wr_en && !rise(ctl_pin_on[3], s.ctl_q[3])
		&& !rise(op_on[3], s.op_q[3]) |=> retry_exhausted[3])
		else $error("exhausted channel left its final state");

	peak_track_a: assert property (
		meas_valid && meas_chan == 3'h0 && meas_value > s.peak[0]
		&& !(clear_faults && clear_page == 3'h0) && !rise(chan_on[0], s.on_q[0])
		|=> s.peak[0] == $past(meas_value))
		else $error("peak did not follow higher value");

	peak_odd_skip_a: assert property (
		meas_valid && meas_chan == 3'h1 && isense_mode[1]
		&& !(clear_faults && clear_page == 3'h1) && !rise(chan_on[1], s.on_q[1])
		|=> s.peak[1] == $past(s.peak[1]))
		else $error("current channel peak changed");

endmodule

// file: tb/frc_far_model.sv
// Far side model: shared timebase tick source and output voltage measurements.
// Assumes the bench raises meas_req for one cycle per wanted measurement.
`timescale 1ns/1ps
module frc_far_model #(
	parameter int TICK_CYC = 40
) (
	input wire logic clk,
	input wire logic tick_en,
	input wire logic meas_req,
	output logic tick,
	output logic meas_valid,
	output logic [2:0] meas_chan,
	output logic [15:0] meas_value
);
	int cnt = 0;
	initial begin
		tick = 0;
		meas_valid = 0;
		meas_chan = 0;
		meas_value = 0;
	end
	// Idle measurement lines toggle so stale values never look valid
	always @(posedge clk) begin
		cnt <= (cnt == TICK_CYC - 1) ? 0 : cnt + 1;
		tick <= tick_en && cnt == TICK_CYC - 1;
		meas_valid <= meas_req;
		meas_chan <= meas_req ? 3'($urandom) : ~meas_chan;
		meas_value <= meas_req ? 16'($urandom) : ~meas_value;
	end
endmodule

// file: tb/frc_top_tb.sv
// Self-checking bench for the fault, retry and restart control block.
// Assumes frc_far_model supplies ticks and measurements.
`timescale 1ns/1ps
module frc_top_tb;
	localparam int TC = 40;
	logic clk = 0, rstn = 0, wr = 0, rd = 0, clr = 0, tick_en = 1, mreq = 0;
	logic [2:0] sel = 0, page = 0, cpage = 0;
	logic [15:0] wdat = 0, rdat;
	logic [7:0] ov = 0, uv = 0, fo = 0, f = 0, isn = 0, ren = 8'hff;
	logic [7:0] ctl = 8'hff, opn = 8'hff, con = 8'hff, con_q = 8'hff;
	logic [7:0] go, exh, hold;
	logic rv, en_out, en_oe_n, tick, mv, vin;
	logic [2:0] mch;
	logic [15:0] mval;
	logic [15:0] pkm [8] = '{default: 16'hf800};
	logic [15:0] mr [8] = '{default: 16'h0};
	int n_fail = 0, num_checks = 0, cyc = 0, tk = 0, t0, i, k;
	assign vin = en_oe_n ? 1'b1 : en_out;

	frc_top #(.QUIET_TICKS(20)) uut (.clk(clk), .rstn(rstn), .reg_wr_en(wr), .reg_rd_en(rd),
		.reg_sel(sel), .reg_page(page), .reg_wdata(wdat), .reg_rdata(rdat), .reg_rvalid(rv),
		.clear_faults(clr), .clear_page(cpage), .output_overvoltage_fault(ov),
		.output_undervoltage_fault(uv), .faulted_off(fo), .retry_en(ren), .ctl_pin_on(ctl),
		.op_on(opn), .chan_on(con), .isense_mode(isn), .shared_timebase_tick(tick),
		.meas_valid(mv), .meas_chan(mch), .meas_value(mval), .vin_en_in(vin),
		.vin_en_out(en_out), .vin_en_oe_n(en_oe_n), .retry_go(go), .retry_exhausted(exh),
		.restart_hold(hold));
	frc_far_model #(.TICK_CYC(TC)) far (.clk(clk), .tick_en(tick_en), .meas_req(mreq),
		.tick(tick), .meas_valid(mv), .meas_chan(mch), .meas_value(mval));

	initial forever #4 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cyc++;
		if (tick)
			tk <= tk + 1;
		if (cyc == 40000) begin
			n_fail++;
			summarize();
		end
	end
	// Peak model
	always @(posedge clk) begin
		for (int c = 0; c < 8; c++) begin
			if ((clr && cpage == c) || (con[c] && !con_q[c]))
				pkm[c] = 16'hf800;
			else if (mv && mch == c && !(c % 2 == 1 && isn[c])
				&& (pkm[c] == 16'hf800 || mval > pkm[c]))
				pkm[c] = mval;
		end
		con_q = con;
	end
	////////////////////////////////////////////////////////////////////////////
	task chk(input logic [15:0] s, input logic [15:0] e);
		num_checks++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	endtask
	task wm(input logic [2:0] s, input logic [15:0] d);
		@(posedge clk);
		wr <= 1;
		sel <= s;
		wdat <= d;
		@(posedge clk);
		wr <= 0;
		if (s < 2)
			mr[s] = {8'h0, d[7:0]};
		else if (s == 2)
			mr[s] = {13'h0, d[2:0]};
		else if (s < 5)
			mr[s] = d;
	endtask
	task ck(input logic [2:0] s, input logic [2:0] p);
		@(posedge clk);
		rd <= 1;
		sel <= s;
		page <= p;
		@(posedge clk);
		rd <= 0;
		#1;
		for (int j = 0; j < 3 && rv !== 1'b1; j++) begin
			@(posedge clk);
			#1;
		end
		chk(16'(rv), 16'h1);
		chk(rdat, s == 5 ? pkm[p] : mr[s]);
	endtask
	task try(input logic eg);
		logic g;
		g = 0;
		@(posedge clk);
		#1;
		while (tick !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		fo[3] <= 1;
		#1 t0 = tk;
		for (int j = 0; j < 400; j++) begin
			@(posedge clk);
			#1;
			if (go[3] === 1'b1) begin
				g = 1;
				break;
			end
			if (exh[3] === 1'b1)
				break;
		end
		chk(16'({g, exh[3]}), 16'({eg, !eg && ren[3]}));
		if (eg)
			chk(16'(tk - t0), 16'h5);
		@(posedge clk);
		fo[3] <= 0;
	endtask
	task rs(input int low, input logic ten, input logic eh);
		@(posedge clk);
		tick_en <= ten;
		@(posedge clk);
		ctl[0] <= 0;
		repeat (low) @(posedge clk);
		ctl[0] <= 1;
		tick_en <= 1;
		@(posedge clk);
		#1 t0 = tk;
		chk(16'(hold[0]), 16'(eh));
		for (int j = 0; j < 400 && hold[0] === 1'b1; j++) begin
			@(posedge clk);
			#1;
		end
		if (eh)
			chk(16'(tk - t0), 16'h5);
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'hb03f));
		repeat (2) @(posedge clk);
		rstn <= 1;
		for (i = 0; i < 8; i++)
			ck(3'(i), 3'h0);
		wm(0, 16'($urandom));
		wm(1, 16'($urandom));
		wm(2, 16'hfffa);
		wm(3, 16'h7fff);
		wm(4, 16'($urandom));
		for (i = 0; i < 8; i++)
			ck(3'(i), 3'(i));
		$display("registers done");
		for (i = 0; i < 16; i++) begin
			k = $urandom;
			f = $urandom;
			wm(3'(i / 8), 16'(k));
			@(posedge clk);
			ov <= i < 8 ? f : 8'h0;
			uv <= i < 8 ? 8'h0 : f;
			repeat (2) @(posedge clk);
			#1 chk(16'({en_out, en_oe_n}), 16'(~|(f & k[7:0])));
			@(posedge clk);
			ov <= 0;
			uv <= 0;
			repeat (2) @(posedge clk);
			#1 chk(16'(en_oe_n), 16'h1);
		end
		$display("input enable done");
		wm(3, 16'h0001);
		ck(3'h3, 3'h0);
		try(1);
		try(1);
		try(0);
		wm(2, 16'h0002);
		try(1);
		try(1);
		try(0);
		@(posedge clk);
		opn[3] <= 0;
		@(posedge clk);
		opn[3] <= 1;
		try(1);
		wm(2, 16'h0001);
		try(1);
		repeat (25 * TC) @(posedge clk);
		try(1);
		wm(2, 16'h0007);
		for (k = 0; k < 8; k++)
			try(1);
		wm(2, 16'h0000);
		try(0);
		ren[3] <= 1'b0;
		wm(2, 16'h0001);
		try(0);
		ren[3] <= 1'b1;
		$display("retry done");
		wm(4, 16'h0001);
		rs(1300, 0, 1);
		rs(1000, 0, 0);
		rs(1300, 1, 0);
		wm(4, 16'h0000);
		rs(1300, 0, 0);
		$display("restart done");
		for (k = 0; k < 3; k++) begin
			@(posedge clk);
			isn <= $urandom;
			for (i = 0; i < 20; i++) begin
				@(posedge clk);
				mreq <= 1;
				@(posedge clk);
				mreq <= 0;
			end
			@(posedge clk);
			con[k + 2] <= 0;
			clr <= 1;
			cpage <= 3'(k * 5 + 2);
			@(posedge clk);
			con[k + 2] <= 1;
			clr <= 0;
			for (i = 0; i < 8; i++)
				ck(3'h5, 3'(i));
		end
		$display("peak done");
		summarize();
	end
endmodule
